// [srs_pkg.sv]
// Constants, types and helpers for the supply, reset and start-up controller.
// Assumes a single 125 MHz bus clock; the slow clock is an enable from it.
package srs_pkg;
  // Clock rates and the slow-clock divider
  localparam int CLK_HZ = 125_000_000;
  localparam int SLOW_HZ = 32_768; // 32 kHz slow clock
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int DIV_W = 12;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CLK = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_ISR = 8'h10;
  localparam logic [7:0] OFF_IMR = 8'h14;
  localparam logic [7:0] OFF_WKEN = 8'h18;
  // Control register fields
  localparam int CTRL_SWRST = 0;
  localparam int CTRL_XTAL = 1;
  localparam int CTRL_SEL = 2;
  localparam int CTRL_SLEEP = 3;
  // Supply mode register fields
  localparam int MODE_BODDIS = 0;
  localparam int MODE_SMEN = 1;
  localparam int MODE_TH_LSB = 4;
  localparam int MODE_SMP_LSB = 8;
  // Clock register fields
  localparam int CLK_MCK_LSB = 0;
  localparam int CLK_FRQ_LSB = 2;
  localparam int CLK_T8_LSB = 8;
  localparam int CLK_T12_LSB = 16;
  // Interrupt bit positions
  localparam int IRQ_W = 4;
  localparam int IRQ_BOD = 0;
  localparam int IRQ_SMON = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_USER = 3;
  // Values after reset, and the reserved frequency code
  localparam logic [1:0] MCK_FAST_RC = 2'h0;
  localparam logic [1:0] FRQ_4MHZ = 2'h0;
  localparam logic [1:0] FRQ_RSVD = 2'h3;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [3:0] TH_RST = 4'h0;
  // Counts in slow ticks
  localparam logic [3:0] SEQ_LAST = 4'h3;
  localparam logic [3:0] EXT_PULSE = 4'hA;
  localparam logic [3:0] EXT_GUARD = 4'h2;
  localparam logic [3:0] XTAL_START = 4'hF;
  localparam logic [3:0] SMP_MAX_LOG = 4'hB;
  typedef enum logic [2:0] {CAUSE_GEN, CAUSE_WAKE, CAUSE_WDT, CAUSE_SW, CAUSE_USER} srs_cause_t;
  typedef enum logic [2:0] {S_OFF, S_SWITCH, S_VREG, S_RUN, S_SLEEP} srs_state_t;
  // Sample period mask: active one tick in 2**lg, capped at 2048
  function automatic logic [10:0] srs_smp_mask(input logic [3:0] lg);
    logic [3:0] l;
    l = (lg > SMP_MAX_LOG) ? SMP_MAX_LOG : lg;
    srs_smp_mask = 11'(({11'h0, 1'b1} << l) - 12'h001);
  endfunction
endpackage

// [srs_ev_if.sv]
// Slow tick and slow-domain event levels shared inside the controller.
// Assumes everything runs on pclk; tick is a one-cycle enable.
`timescale 1ns/10ps
interface srs_ev_if;
  logic tick;
  logic io_low;
  logic core_low;
  logic pin_low;
  logic wdt;
  logic smon_low;
  logic [15:0] wake;
  modport div (output tick);
  modport sync (input tick, output io_low, core_low, pin_low, wdt, smon_low, wake);
  modport core (input tick, io_low, core_low, pin_low, wdt, smon_low, wake);
endinterface

// [srs_tick_div.sv]
// Divider making the 32 kHz slow-clock enable from pclk.
// Assumes pclk at the package rate.
`timescale 1ns/10ps
module srs_tick_div (
  input wire logic pclk,
  input wire logic presetn,
  srs_ev_if.div ev
);
  logic [srs_pkg::DIV_W-1:0] cnt_reg;
  wire last = (cnt_reg == srs_pkg::DIV_W'(srs_pkg::SLOW_DIV - 1));

  // Free-running count, tick on wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      ev.tick <= 1'b0;
    end else begin
      cnt_reg <= last ? '0 : cnt_reg + 1'b1;
      ev.tick <= last;
    end
  end
endmodule // srs_tick_div

// [srs_ev_sync.sv]
// Synchroniser bringing supply, pin and wake events into the slow domain.
// Assumes raw levels may be asynchronous; levels change only on ticks.
`timescale 1ns/10ps
module srs_ev_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic io_supply_low,
  input wire logic core_supply_low,
  input wire logic ext_rst_pin_in,
  input wire logic wdt_rst_req,
  input wire logic smon_below,
  input wire logic [15:0] wakeup_pins,
  srs_ev_if.sync ev
);
  logic [20:0] s1_reg;
  logic [20:0] s2_reg;
  wire [20:0] raw = {wakeup_pins, smon_below, wdt_rst_req, !ext_rst_pin_in,
                     core_supply_low, io_supply_low};

  // Two flops, then capture on the slow tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      {ev.wake, ev.smon_low, ev.wdt, ev.pin_low, ev.core_low, ev.io_low} <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      if (ev.tick) begin
        {ev.wake, ev.smon_low, ev.wdt, ev.pin_low, ev.core_low, ev.io_low} <= s2_reg;
      end
    end
  end
endmodule // srs_ev_sync

// [srs_top.sv]
// Supply, reset and slow-clock start-up controller with an APB slave.
// Assumes analog comparators and oscillators outside; one clock, pclk.
`timescale 1ns/10ps
module srs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_supply_low,
  input wire logic core_supply_low,
  input wire logic smon_below,
  input wire logic ext_rst_pin_in,
  output logic ext_rst_pin_out,
  output logic ext_rst_pin_oe,
  input wire logic wdt_rst_req,
  input wire logic [15:0] wakeup_pins,
  output logic [15:0] fast_startup_sources,
  output logic core_rst_n,
  output logic pwr_switch_en,
  output logic vreg_en,
  output logic bod_en,
  output logic smon_active,
  output logic [3:0] smon_thresh,
  output logic xtal_osc_en,
  output logic rc_slow_en,
  output logic slow_clk_sel,
  output logic [1:0] mck_src,
  output logic [1:0] fast_rc_freq,
  output logic [7:0] fast_rc_trim,
  output logic irq
);
  srs_ev_if ev ();

  srs_tick_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ev(ev)
  );

  srs_ev_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .io_supply_low(io_supply_low),
    .core_supply_low(core_supply_low),
    .ext_rst_pin_in(ext_rst_pin_in),
    .wdt_rst_req(wdt_rst_req),
    .smon_below(smon_below),
    .wakeup_pins(wakeup_pins),
    .ev(ev)
  );

  srs_pkg::srs_state_t state_reg, state_next;
  srs_pkg::srs_cause_t cause_reg, cause_next;
  logic [3:0] seq_cnt_reg;
  logic [3:0] ext_cnt_reg;
  logic [3:0] xtal_cnt_reg;
  logic [10:0] smp_cnt_reg;
  logic bod_dis_reg, smon_en_reg, xtal_en_reg, sel_req_reg, sel_done_reg;
  logic sw_req_reg, sleep_req_reg;
  logic [3:0] thresh_reg, smp_reg;
  logic [1:0] mck_reg, freq_reg;
  logic [7:0] trim8_reg, trim12_reg;
  logic [15:0] wken_reg;
  logic [srs_pkg::IRQ_W-1:0] isr_reg, imr_reg, isr_next, isr_set;

  // APB decode; one wait state so read data leave a flop
  wire acc = psel & penable;
  wire wr = acc & pready & pwrite;
  wire hit_ctrl = (paddr == srs_pkg::OFF_CTRL);
  wire hit_mode = (paddr == srs_pkg::OFF_MODE);
  wire hit_clk = (paddr == srs_pkg::OFF_CLK);
  wire hit_stat = (paddr == srs_pkg::OFF_STAT);
  wire hit_isr = (paddr == srs_pkg::OFF_ISR);
  wire hit_imr = (paddr == srs_pkg::OFF_IMR);
  wire hit_wken = (paddr == srs_pkg::OFF_WKEN);
  wire hit = hit_ctrl | hit_mode | hit_clk | hit_stat | hit_isr | hit_imr | hit_wken;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_mode = wr & hit_mode;
  wire wr_clk = wr & hit_clk;

  wire xtal_ready = (xtal_cnt_reg == srs_pkg::XTAL_START);

  // Read views
  wire [31:0] mode_view = {20'h0_0000, smp_reg, thresh_reg, 2'b00, smon_en_reg, bod_dis_reg};
  wire [31:0] clk_view = {8'h00, trim12_reg, trim8_reg, 4'h0, freq_reg, mck_reg};
  wire [31:0] stat_view = {24'h00_0000, (state_reg == srs_pkg::S_RUN), !bod_dis_reg,
                           ev.smon_low, xtal_ready, sel_done_reg, cause_reg};
  wire [31:0] ctrl_view = {28'h000_0000, sleep_req_reg, sel_req_reg, xtal_en_reg, sw_req_reg};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_view :
                       hit_mode ? mode_view :
                       hit_clk ? clk_view :
                       hit_stat ? stat_view :
                       hit_isr ? {28'h000_0000, isr_reg} :
                       hit_imr ? {28'h000_0000, imr_reg} :
                       hit_wken ? {16'h0000, wken_reg} : 32'h0000_0000;

  // Slow-domain decisions, all gated by the tick
  wire tick = ev.tick;
  wire in_run = (state_reg == srs_pkg::S_RUN);
  wire step_done = (seq_cnt_reg == srs_pkg::SEQ_LAST);
  wire bod_hit = ev.core_low & !bod_dis_reg;
  wire user_hit = ev.pin_low & (ext_cnt_reg == 4'h0);
  wire [15:0] wake_hit = ev.wake & wken_reg;
  wire rst_req = ev.wdt | sw_req_reg | user_hit;
  wire run_rst = tick & in_run & !ev.io_low & !bod_hit & rst_req;
  wire sw_take = run_rst & !ev.wdt & sw_req_reg;
  wire go_sleep = tick & in_run & !ev.io_low & !bod_hit & !rst_req & sleep_req_reg;
  wire [10:0] smp_mask = srs_pkg::srs_smp_mask(smp_reg);
  wire smon_on = smon_en_reg & ((smp_cnt_reg & smp_mask) == 11'h000);
  wire frq_ok = (pwdata[srs_pkg::CLK_FRQ_LSB +: 2] != srs_pkg::FRQ_RSVD);

  // Start-up, reset and sleep sequencing
  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    if (tick) begin
      if (ev.io_low) begin
        state_next = srs_pkg::S_OFF;
        cause_next = srs_pkg::CAUSE_GEN;
      end else begin
        case (state_reg)
          srs_pkg::S_OFF: state_next = srs_pkg::S_SWITCH;
          srs_pkg::S_SWITCH: begin
            if (step_done) state_next = srs_pkg::S_VREG;
          end
          srs_pkg::S_VREG: begin
            if (step_done) state_next = srs_pkg::S_RUN;
          end
          srs_pkg::S_RUN: begin
            if (bod_hit) begin
              state_next = srs_pkg::S_VREG;
              cause_next = srs_pkg::CAUSE_GEN;
            end else if (ev.wdt) begin
              state_next = srs_pkg::S_VREG;
              cause_next = srs_pkg::CAUSE_WDT;
            end else if (sw_req_reg) begin
              state_next = srs_pkg::S_VREG;
              cause_next = srs_pkg::CAUSE_SW;
            end else if (user_hit) begin
              state_next = srs_pkg::S_VREG;
              cause_next = srs_pkg::CAUSE_USER;
            end else if (sleep_req_reg) begin
              state_next = srs_pkg::S_SLEEP;
            end
          end
          srs_pkg::S_SLEEP: begin
            if (|wake_hit) begin
              state_next = srs_pkg::S_SWITCH;
              cause_next = srs_pkg::CAUSE_WAKE;
            end
          end
          default: state_next = srs_pkg::S_OFF;
        endcase
      end
    end
  end

  // Event flags; a set in the clearing cycle wins
  assign isr_set = {run_rst & !ev.wdt & !sw_req_reg,
                    tick & (state_reg == srs_pkg::S_SLEEP) & !ev.io_low & (|wake_hit),
                    tick & smon_active & ev.smon_low,
                    tick & in_run & bod_hit};
  assign isr_next = (isr_reg & ~((wr & hit_isr) ? pwdata[srs_pkg::IRQ_W-1:0] : '0)) | isr_set;

  // State, cause and slow counters; cause kept over core loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= srs_pkg::S_OFF;
      cause_reg <= srs_pkg::CAUSE_GEN;
      seq_cnt_reg <= 4'h0;
      smp_cnt_reg <= 11'h000;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      if (state_next != state_reg) seq_cnt_reg <= 4'h0;
      else if (tick) seq_cnt_reg <= seq_cnt_reg + 4'h1;
      if (tick) smp_cnt_reg <= smp_cnt_reg + 11'h001;
    end
  end

  // Reset pin pulse; the guard ticks mask our own echo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_reg <= 4'h0;
    end else if (run_rst) begin
      ext_cnt_reg <= srs_pkg::EXT_PULSE;
    end else if (tick && ext_cnt_reg != 4'h0) begin
      ext_cnt_reg <= ext_cnt_reg - 4'h1;
    end
  end

  // Requests from software, consumed on a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req_reg <= 1'b0;
      sleep_req_reg <= 1'b0;
    end else begin
      sw_req_reg <= (sw_req_reg & !sw_take) | (wr_ctrl & pwdata[srs_pkg::CTRL_SWRST]);
      sleep_req_reg <= (sleep_req_reg & !go_sleep) | (wr_ctrl & pwdata[srs_pkg::CTRL_SLEEP]);
    end
  end

  // Configuration; only the I/O supply reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {bod_dis_reg, smon_en_reg, thresh_reg, smp_reg} <= {2'b00, srs_pkg::TH_RST, 4'h0};
      {mck_reg, freq_reg} <= {srs_pkg::MCK_FAST_RC, srs_pkg::FRQ_4MHZ};
      {trim8_reg, trim12_reg} <= {srs_pkg::TRIM_RST, srs_pkg::TRIM_RST};
      {xtal_en_reg, sel_req_reg, wken_reg, imr_reg} <= '0;
    end else if (ev.io_low) begin
      {bod_dis_reg, smon_en_reg, thresh_reg, smp_reg} <= {2'b00, srs_pkg::TH_RST, 4'h0};
      {mck_reg, freq_reg} <= {srs_pkg::MCK_FAST_RC, srs_pkg::FRQ_4MHZ};
      {trim8_reg, trim12_reg} <= {srs_pkg::TRIM_RST, srs_pkg::TRIM_RST};
      {xtal_en_reg, sel_req_reg, wken_reg, imr_reg} <= '0;
    end else begin
      if (wr_mode) begin
        bod_dis_reg <= pwdata[srs_pkg::MODE_BODDIS];
        smon_en_reg <= pwdata[srs_pkg::MODE_SMEN];
        thresh_reg <= pwdata[srs_pkg::MODE_TH_LSB +: 4];
        smp_reg <= pwdata[srs_pkg::MODE_SMP_LSB +: 4];
      end
      if (wr_clk) begin
        mck_reg <= pwdata[srs_pkg::CLK_MCK_LSB +: 2];
        if (frq_ok) freq_reg <= pwdata[srs_pkg::CLK_FRQ_LSB +: 2];
        trim8_reg <= pwdata[srs_pkg::CLK_T8_LSB +: 8];
        trim12_reg <= pwdata[srs_pkg::CLK_T12_LSB +: 8];
      end
      if (wr_ctrl) begin
        xtal_en_reg <= xtal_en_reg | pwdata[srs_pkg::CTRL_XTAL];
        sel_req_reg <= sel_req_reg | pwdata[srs_pkg::CTRL_SEL];
      end
      if (wr & hit_wken) wken_reg <= pwdata[15:0];
      if (wr & hit_imr) imr_reg <= pwdata[srs_pkg::IRQ_W-1:0];
    end
  end

  // Crystal start count and one-way switch of the slow clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_cnt_reg <= 4'h0;
      sel_done_reg <= 1'b0;
    end else if (ev.io_low) begin
      xtal_cnt_reg <= 4'h0;
      sel_done_reg <= 1'b0;
    end else if (tick) begin
      if (xtal_en_reg && !xtal_ready) xtal_cnt_reg <= xtal_cnt_reg + 4'h1;
      if (sel_req_reg && xtal_ready) sel_done_reg <= 1'b1;
    end
  end

  // Interrupt status and APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_reg <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      isr_reg <= isr_next;
      pready <= acc & !pready;
      pslverr <= acc & !pready & !hit; // Unmapped answers with an error
      if (acc && !pready) prdata <= rd_mux;
    end
  end

  // Outputs, all from flops, following the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pwr_switch_en, vreg_en, core_rst_n} <= 3'b000;
      {ext_rst_pin_out, ext_rst_pin_oe} <= 2'b00;
      {bod_en, smon_active, xtal_osc_en, slow_clk_sel} <= 4'b1000;
      rc_slow_en <= 1'b1;
      smon_thresh <= srs_pkg::TH_RST;
      mck_src <= srs_pkg::MCK_FAST_RC;
      fast_rc_freq <= srs_pkg::FRQ_4MHZ;
      fast_rc_trim <= srs_pkg::TRIM_RST;
      fast_startup_sources <= 16'h0000;
      irq <= 1'b0;
    end else begin
      pwr_switch_en <= (state_next == srs_pkg::S_SWITCH) || (state_next == srs_pkg::S_VREG)
                       || (state_next == srs_pkg::S_RUN);
      vreg_en <= (state_next == srs_pkg::S_VREG) || (state_next == srs_pkg::S_RUN);
      core_rst_n <= (state_next == srs_pkg::S_RUN);
      ext_rst_pin_out <= 1'b0; // Open drain: only ever pulls low
      ext_rst_pin_oe <= (ext_cnt_reg > srs_pkg::EXT_GUARD);
      bod_en <= !bod_dis_reg;
      smon_active <= tick ? smon_on : (smon_active & smon_en_reg); // Off at once
      smon_thresh <= thresh_reg;
      xtal_osc_en <= xtal_en_reg | sel_done_reg;
      rc_slow_en <= !sel_done_reg;
      slow_clk_sel <= sel_done_reg;
      mck_src <= mck_reg;
      fast_rc_freq <= freq_reg;
      fast_rc_trim <= (freq_reg == 2'h1) ? trim8_reg :
                      (freq_reg == 2'h2) ? trim12_reg : srs_pkg::TRIM_RST;
      fast_startup_sources <= wake_hit;
      irq <= |(isr_next & imr_reg);
    end
  end

  // Checks and coverage
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_io_por_reset: assert property (tick && ev.io_low |=> !core_rst_n && !vreg_en)
    else $error("core not reset on io supply loss");
  a_bod_core_reset: assert property (tick && in_run && bod_hit |=> !core_rst_n)
    else $error("brownout did not reset core");
  a_bod_disable: assert property (wr_mode && pwdata[0] |=> ##1 !bod_en)
    else $error("brownout not disabled by write");
  a_smon_idle: assert property (!smon_en_reg && !$past(smon_en_reg) |-> ##1 !smon_active)
    else $error("monitor active while disabled");
  a_cause_on_tick: assert property ($changed(cause_reg) |-> $past(tick))
    else $error("reset cause changed off tick");
  a_pin_pulse: assert property ($rose(ext_rst_pin_oe) |-> !ext_rst_pin_out ##1
                                ext_rst_pin_oe [*8])
    else $error("reset pin pulse too short");
  a_slow_exclusive: assert property (##1 slow_clk_sel != rc_slow_en)
    else $error("both slow oscillators selected");
  a_seq_order: assert property ($rose(core_rst_n) |-> vreg_en && pwr_switch_en
                                && $past(vreg_en))
    else $error("core released before supplies");
  a_mck_hold: assert property (!wr_clk && !ev.io_low |=> ##1 $stable(mck_src))
    else $error("master clock source moved unasked");

  c_wake: cover property (tick && state_reg == srs_pkg::S_SLEEP && |wake_hit);
  c_user_rst: cover property (run_rst && user_hit);
  c_xtal_sel: cover property ($rose(slow_clk_sel));
  c_smon_evt: cover property (isr_set[srs_pkg::IRQ_SMON]);
endmodule // srs_top

// [srs_rail_model.sv]
// Board model: supply rails, monitor comparator, push-button and reset pin pull-up.
// Assumes the reset pin is open drain, so the controller can only pull it low.
`timescale 1ns/10ps
module srs_rail_model (
  input wire logic monitor_dip,
  input wire logic button_pressed,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_level,
  output logic smon_below,
  output logic io_supply_low,
  output logic core_supply_low
);
  // Rails stay healthy; a dip would restart the whole run
  assign io_supply_low = 1'b0;
  assign core_supply_low = 1'b0;
  // Comparator follows the commanded dip on the I/O supply
  assign smon_below = monitor_dip;
  // Wired-AND with pull-up, so a released pin never shows a stale low
  assign pin_level = ~((pin_oe & ~pin_out) | button_pressed);
endmodule // srs_rail_model

// [srs_top_tb.sv]
// Self-checking bench: APB register access, start-up order, monitor irq, software reset.
// Assumes the fixed 3814-cycle slow tick; waits are bounded in ticks.
`timescale 1ns/10ps
module srs_top_tb;
  localparam int TK = 3814;
  localparam int MAXC = 90000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic smon_dip, button, pin_level, smon_below, io_supply_low, core_supply_low;
  logic ext_rst_pin_out, ext_rst_pin_oe, core_rst_n, pwr_switch_en, vreg_en, bod_en;
  logic smon_active, xtal_osc_en, rc_slow_en, slow_clk_sel;
  logic [3:0] smon_thresh;
  logic [1:0] mck_src, fast_rc_freq;
  logic [7:0] fast_rc_trim;
  logic [15:0] wakeup_pins, fast_startup_sources;
  int bad_count, n_compared;
  int cyc = 0;

  srs_top u_srs_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .io_supply_low, .core_supply_low, .smon_below,
    .ext_rst_pin_in(pin_level), .ext_rst_pin_out, .ext_rst_pin_oe, .wdt_rst_req(1'b0),
    .wakeup_pins, .fast_startup_sources, .core_rst_n, .pwr_switch_en, .vreg_en, .bod_en,
    .smon_active, .smon_thresh, .xtal_osc_en, .rc_slow_en, .slow_clk_sel, .mck_src,
    .fast_rc_freq, .fast_rc_trim, .irq);
  srs_rail_model u_srs_rail_model (.monitor_dip(smon_dip), .button_pressed(button),
    .pin_oe(ext_rst_pin_oe), .pin_out(ext_rst_pin_out), .pin_level, .smon_below,
    .io_supply_low, .core_supply_low);

  // 125 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard; the run needs about 18 slow ticks, near 69k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == MAXC) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; pready, read data and error taken at the edge that ends it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Registered outputs follow one edge after the write lands
    repeat (2) @(negedge pclk);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = pwr_switch_en;
      1: pick = vreg_en;
      2: pick = core_rst_n;
      default: pick = ext_rst_pin_oe;
    endcase
  endfunction

  // Bounded wait for a level; the caller compares afterwards
  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pick(k) !== v && n < lim);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    smon_dip = 1'b0;
    button = 1'b0;
    wakeup_pins = 16'h0000;
    bad_count = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'({bod_en, rc_slow_en, smon_active, xtal_osc_en, slow_clk_sel, mck_src,
      fast_rc_freq}), 32'h0000_0180);
    chk(32'({core_rst_n, pwr_switch_en, smon_thresh}), 32'h0000_0000);
    // Unmapped place refused, reads zero
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    // Every fast RC frequency code, then the reserved code is ignored
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, srs_pkg::OFF_CLK, 32'h00A5_5A00 | 32'(i << 2));
      chk(32'(fast_rc_freq), 32'(i));
      chk(32'(fast_rc_trim), (i == 1) ? 32'h0000_005A : (i == 2) ? 32'h0000_00A5 : 32'h0);
    end
    apb(1'b1, srs_pkg::OFF_CLK, 32'h00A5_5A0C);
    apb(1'b0, srs_pkg::OFF_CLK, 32'h0000_0000);
    chk(q, 32'h00A5_5A08);
    chk(32'(mck_src), 32'h0000_0000);
    // Brownout off before any low power, monitor on at step 5, continuous
    apb(1'b1, srs_pkg::OFF_MODE, 32'h0000_0053);
    chk(32'({bod_en, smon_thresh}), 32'h0000_0005);
    // Crystal enabled and selected early; it is ready after 15 ticks, shortly before the end
    apb(1'b1, srs_pkg::OFF_CTRL, 32'h0000_0006);
    apb(1'b1, srs_pkg::OFF_IMR, 32'h0000_0002);
    apb(1'b1, srs_pkg::OFF_WKEN, 32'h0000_FFFF);
    @(posedge pclk);
    smon_dip <= 1'b1;
    wakeup_pins <= 16'hA5A5;
    // Start-up order: switches, regulator, then core reset release
    wait_for(0, 1'b1, 3 * TK);
    chk(32'({pwr_switch_en, vreg_en, core_rst_n}), 32'h0000_0004);
    wait_for(1, 1'b1, 6 * TK);
    chk(32'({pwr_switch_en, vreg_en, core_rst_n}), 32'h0000_0006);
    wait_for(2, 1'b1, 6 * TK);
    chk(32'({pwr_switch_en, vreg_en, core_rst_n}), 32'h0000_0007);
    chk(32'(fast_startup_sources), 32'h0000_A5A5);
    chk(32'({smon_active, irq}), 32'h0000_0003);
    chk(32'({xtal_osc_en, rc_slow_en, slow_clk_sel}), 32'h0000_0006);
    chk(32'(fast_rc_trim), 32'h0000_00A5);
    @(posedge pclk);
    smon_dip <= 1'b0;
    wakeup_pins <= 16'h0000;
    apb(1'b0, srs_pkg::OFF_STAT, 32'h0000_0000);
    chk(q & 32'h0000_00C7, 32'h0000_0080);
    apb(1'b0, srs_pkg::OFF_ISR, 32'h0000_0000);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    // Masking hides the pending bit without clearing it
    apb(1'b1, srs_pkg::OFF_IMR, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, srs_pkg::OFF_IMR, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    // Software reset: core reset, shaped pin pulse, restart, cause kept
    apb(1'b1, srs_pkg::OFF_CTRL, 32'h0000_0001);
    wait_for(2, 1'b0, 3 * TK);
    chk(32'(core_rst_n), 32'h0000_0000);
    wait_for(3, 1'b1, 3 * TK);
    chk(32'({ext_rst_pin_oe, pin_level}), 32'h0000_0002);
    wait_for(3, 1'b0, 12 * TK);
    chk(32'(pin_level), 32'h0000_0001);
    wait_for(2, 1'b1, 16 * TK);
    chk(32'(core_rst_n), 32'h0000_0001);
    apb(1'b0, srs_pkg::OFF_STAT, 32'h0000_0000);
    chk(q & 32'h0000_00C7, 32'h0000_0083);
    chk(q & 32'h0000_0018, 32'h0000_0018);
    chk(32'({xtal_osc_en, rc_slow_en, slow_clk_sel}), 32'h0000_0005);
    apb(1'b0, srs_pkg::OFF_MODE, 32'h0000_0000);
    chk(q, 32'h0000_0053);
    // Write one to clear, then irq drops
    apb(1'b1, srs_pkg::OFF_ISR, 32'h0000_000F);
    apb(1'b0, srs_pkg::OFF_ISR, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    results();
  end
endmodule // srs_top_tb
